// ===== src/adcps_pkg.sv
// constants for the adc polling sequencer
package adcps_pkg;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADCPS_OFS_RESULT_HI = 8'h07;
    localparam logic [7:0] ADCPS_OFS_RESULT_LO = 8'h08;
    localparam logic [7:0] ADCPS_OFS_CONFIG    = 8'h09;
    localparam logic [7:0] ADCPS_OFS_CHANNEL   = 8'h0a;
    localparam logic [7:0] ADCPS_OFS_INPUT_CURRENT_SENSE      = 8'h10;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int ADCPS_CFG_EN_BIT      = 7;
    localparam int ADCPS_CFG_ONESHOT_BIT = 6;
    localparam int ADCPS_CFG_SWEEP_BIT   = 5;
    localparam int ADCPS_CFG_BUFDIS_BIT  = 4;
    localparam int ADCPS_CHN_READY_BIT   = 7;
    localparam int ADCPS_CHN_READ_LSB    = 0;
    localparam int ADCPS_CHN_CONV_LSB    = 3;
    // ****************************************************************
    // reset values and channel codes
    // ****************************************************************
    localparam logic [7:0]  ADCPS_CONFIG_RST  = 8'h00;
    localparam logic [7:0]  ADCPS_INPUT_CURRENT_SENSE_RST    = 8'h00;
    localparam logic [2:0]  ADCPS_CH_FIRST    = 3'h0;
    localparam logic [2:0]  ADCPS_CH_LAST     = 3'h6;
    localparam logic [11:0] ADCPS_RESULT_RST  = 12'h000;
    localparam int          ADCPS_NUM_CH      = 7;
    typedef enum logic [1:0] {
        ADCPS_IDLE = 2'b00,
        ADCPS_CONV = 2'b01,
        ADCPS_WAIT = 2'b11
    } adcps_state_type;
endpackage

// ===== src/adcps_result_mem.sv
// per-channel result store with registered read data
`timescale 1ns/10ps
module adcps_result_mem
    import adcps_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_ch,
    input  wire logic [11:0] wr_data,
    input  wire logic [2:0]  rd_ch,
    output logic      [11:0] rd_data
);
    logic [11:0] mem_r [ADCPS_NUM_CH];

    // new results overwrite unconditionally, no host handshake
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < ADCPS_NUM_CH; i++) begin
                mem_r[i] <= ADCPS_RESULT_RST;
            end
            rd_data <= ADCPS_RESULT_RST;
        end else begin
            if (wr_en && (wr_ch <= ADCPS_CH_LAST)) begin
                mem_r[wr_ch] <= wr_data;
            end
            // unused code 7 reads as zero
            rd_data <= (rd_ch <= ADCPS_CH_LAST) ? mem_r[rd_ch]
                                                : ADCPS_RESULT_RST;
        end
    end
endmodule

// ===== src/adcps_top.sv
// polling sequencer for the monitoring converter, with register port
`timescale 1ns/10ps
// Summary of operation
// - writing one to the enable bit starts the conversion sequence when one-shot is clear, sweep set and the buffer enabled.
// - while polling the mux steps through every channel and repeats.
// - each new result overwrites that channel's stored result at once.
// - data ready sets only after every channel of a pass has converted.
// - the interrupt output stays released in polling mode.
// - the read selector picks which stored result the result registers show.
// - channel codes are binary indices 0 to 6, code 7 unused.
// - one result is shown through a seven-to-one select, high eight bits then low four.
module adcps_top
    import adcps_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // converter core
    output logic      [2:0]  convert_channel_selector,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             converter_buffer_disable,
    output logic      [1:0]  input_limit_field,
    output logic             host_interrupt_n
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]      config_r;
    logic [2:0]      read_sel_r;
    logic [7:0]      input_current_sense_r;
    logic            ready_r;
    logic            ready_nxt;
    logic [2:0]      ch_r;
    logic [2:0]      ch_nxt;
    adcps_state_type state_r;
    adcps_state_type state_nxt;
    logic            start_r;
    logic [11:0]     result;

    // ****************************************************************
    // decode
    // ****************************************************************
    // one address compare shared by the write strobes and the read mux
    function automatic logic adcps_hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return addr == ofs;
    endfunction

    wire logic hit_hi   = adcps_hit(reg_addr, ADCPS_OFS_RESULT_HI);
    wire logic hit_lo   = adcps_hit(reg_addr, ADCPS_OFS_RESULT_LO);
    wire logic hit_cfg  = adcps_hit(reg_addr, ADCPS_OFS_CONFIG);
    wire logic hit_chn  = adcps_hit(reg_addr, ADCPS_OFS_CHANNEL);
    wire logic hit_input_current_sense = adcps_hit(reg_addr, ADCPS_OFS_INPUT_CURRENT_SENSE);
    wire logic wr_cfg   = reg_wr && hit_cfg;
    wire logic wr_chn   = reg_wr && hit_chn;
    wire logic wr_input_current_sense  = reg_wr && hit_input_current_sense;
    wire logic en       = config_r[ADCPS_CFG_EN_BIT];
    // polling only when one-shot clear, sweep set, buffer enabled
    wire logic poll_mode = !config_r[ADCPS_CFG_ONESHOT_BIT]
                         && config_r[ADCPS_CFG_SWEEP_BIT]
                         && !config_r[ADCPS_CFG_BUFDIS_BIT];
    wire logic running   = en && poll_mode;
    wire logic last_ch   = (ch_r == ADCPS_CH_LAST);
    wire logic capture   = (state_r == ADCPS_WAIT) && conv_done;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // clearing enable drops a conversion in flight; its late done is
    // ignored because the machine has already left the wait state
    always_comb begin
        state_nxt = state_r;
        ch_nxt    = ch_r;
        unique case (state_r)
            ADCPS_IDLE: begin
                ch_nxt = ADCPS_CH_FIRST;
                if (running) begin
                    state_nxt = ADCPS_CONV;
                end
            end
            ADCPS_CONV: begin
                state_nxt = running ? ADCPS_WAIT : ADCPS_IDLE;
            end
            ADCPS_WAIT: begin
                if (capture) begin
                    // ascending order, wrap after last code
                    ch_nxt = last_ch ? ADCPS_CH_FIRST
                                     : ch_r + 3'h1;
                    state_nxt = running ? ADCPS_CONV
                                        : ADCPS_IDLE;
                end else if (!running) begin
                    state_nxt = ADCPS_IDLE;
                end
            end
            default: state_nxt = ADCPS_IDLE;
        endcase
    end

    // sticky once a full pass finished; a fresh start clears it unless a
    // last-channel capture lands in the same cycle, where the set wins
    wire logic en_rise   = wr_cfg && reg_wdata[ADCPS_CFG_EN_BIT] && !en;
    wire logic start_nxt = (state_nxt == ADCPS_CONV);

    always_comb begin
        ready_nxt = ready_r;
        if (en_rise) begin
            ready_nxt = 1'b0;
        end
        if (capture && last_ch) begin
            ready_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ADCPS_IDLE;
            ch_r    <= ADCPS_CH_FIRST;
            ready_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ch_r    <= ch_nxt;
            ready_r <= ready_nxt;
            start_r <= start_nxt;
        end
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_r   <= ADCPS_CONFIG_RST;
            read_sel_r <= ADCPS_CH_FIRST;
            input_current_sense_r     <= ADCPS_INPUT_CURRENT_SENSE_RST;
        end else begin
            if (wr_cfg) begin
                config_r <= reg_wdata;
            end
            // status bits are read only; a write keeps just the selector
            if (wr_chn) begin
                read_sel_r <= reg_wdata[ADCPS_CHN_READ_LSB +: 3];
            end
            if (wr_input_current_sense) begin
                input_current_sense_r <= reg_wdata;
            end
        end
    end

    adcps_result_mem u_mem (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (capture),
        .wr_ch   (ch_r),
        .wr_data (conv_data),
        .rd_ch   (read_sel_r),
        .rd_data (result)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    // high eight result bits at one offset, low four at the next; the
    // memory adds a cycle, so a new selector shows after two edges
    wire logic [7:0] hi_view  = result[11:4];
    wire logic [7:0] lo_view  = {result[3:0], 4'h0};
    wire logic [7:0] chn_view = {ready_r, 1'b0, ch_r, read_sel_r};
    wire logic [7:0] rd_mux =
        hit_hi   ? hi_view  :
        hit_lo   ? lo_view  :
        hit_cfg  ? config_r :
        hit_chn  ? chn_view :
        hit_input_current_sense ? input_current_sense_r   : 8'h00;
    // idle bus reads zero so a late sample never sees a stale byte
    wire logic [7:0] rdata_nxt = reg_rd ? rd_mux : 8'h00;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ****************************************************************
    // converter outputs
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            convert_channel_selector <= ADCPS_CH_FIRST;
            conv_start               <= 1'b0;
            converter_buffer_disable <= 1'b0;
            input_limit_field        <= 2'b00;
            host_interrupt_n         <= 1'b1;
        end else begin
            convert_channel_selector <= ch_r;
            conv_start               <= start_r;
            converter_buffer_disable <= config_r[ADCPS_CFG_BUFDIS_BIT];
            input_limit_field        <= input_current_sense_r[1:0];
            // completion never pulls the interrupt in this block
            host_interrupt_n         <= 1'b1;
        end
    end
endmodule

// ===== verif/adcps_properties.sv
// port assertions for the polling sequencer
`timescale 1ns/10ps
module adcps_properties
    import adcps_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic [2:0]  convert_channel_selector,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic [11:0] conv_data,
    input wire logic        converter_buffer_disable,
    input wire logic [1:0]  input_limit_field,
    input wire logic        host_interrupt_n
);
    logic [2:0] last_r;
    logic       seen_r;
    wire logic  cfg_wr = reg_wr && reg_addr == ADCPS_OFS_CONFIG;
    wire logic  lo_rd  = reg_rd && reg_addr == ADCPS_OFS_RESULT_LO;
    wire logic  mapped = reg_addr inside {[8'h07:8'h0a], 8'h10};
    wire logic [2:0] sel = convert_channel_selector;
    wire logic [2:0] nxt = (last_r == ADCPS_CH_LAST) ? ADCPS_CH_FIRST
                                                     : last_r + 3'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a config write restarts the order check, the sweep may restart at 0
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_r <= 1'b0;
            last_r <= ADCPS_CH_FIRST;
        end else if (cfg_wr) begin
            seen_r <= 1'b0;
        end else if (conv_start) begin
            seen_r <= 1'b1;
            last_r <= sel;
        end
    end
    a_irq_released: assert property (host_interrupt_n)
        else $error("interrupt output driven low");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    a_sel_held: assert property (conv_start |=> $stable(sel)[*3])
        else $error("selector moved during conversion");
    a_step_order: assert property (
        conv_start && seen_r |-> sel == nxt)
        else $error("channel out of ascending order");
    a_poll_begins: assert property (cfg_wr && reg_wdata == 8'ha0
        |-> ##[1:4] conv_start && sel == ADCPS_CH_FIRST)
        else $error("polling did not start at channel 0");
    a_idle_rdata: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not cleared");
    a_unmapped_zero: assert property (
        reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_lo_nibble: assert property (lo_rd |=> reg_rdata[3:0] == 4'h0)
        else $error("low result nibble not zero");
    a_bufdis_copy: assert property (cfg_wr |-> ##2
        converter_buffer_disable == $past(reg_wdata[4], 2))
        else $error("buffer disable not copied");
    a_limit_copy: assert property (
        reg_wr && reg_addr == ADCPS_OFS_INPUT_CURRENT_SENSE |-> ##2
        input_limit_field == $past(reg_wdata[1:0], 2))
        else $error("limit field not copied");
    c_last_done: cover property (conv_done && sel == ADCPS_CH_LAST);
    c_hi_read: cover property (reg_rd && reg_addr == ADCPS_OFS_RESULT_HI);
    c_restart: cover property (conv_start && sel == ADCPS_CH_FIRST);
endmodule
bind adcps_top adcps_properties i_props (.*);

// ===== verif/adcps_conv_model.sv
// converter core model answering each start after 3 to 10 cycles
`timescale 1ns/10ps
module adcps_conv_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        conv_start,
    input  wire logic [2:0]  convert_channel_selector,
    input  wire logic [2:0]  lag,
    input  wire logic [8:0]  salt,
    output logic             conv_done,
    output logic      [11:0] conv_data
);
    logic [3:0]  cnt_r;
    logic        busy_r;
    logic [11:0] val_r;
    // data outside the done cycle is inverted so stale values never match
    assign conv_data = conv_done ? val_r : ~val_r;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {busy_r, conv_done, cnt_r, val_r} <= '0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                busy_r <= 1'b1;
                cnt_r  <= {1'b0, lag} + 4'h2;
                val_r  <= {salt, convert_channel_selector};
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r    <= 1'b0;
                conv_done <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule

// ===== verif/adcps_top_tb.sv
// self-checking bench for the polling sequencer
`timescale 1ns/10ps
module adcps_top_tb
    import adcps_pkg::*;
;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
    logic [2:0] convert_channel_selector, lag = 3'h0;
    logic conv_start, conv_done, converter_buffer_disable, host_interrupt_n;
    logic [11:0] conv_data, mem [8];
    logic [1:0] input_limit_field;
    logic [8:0] salt = 9'h000;
    logic en_m = 1'b0;
    int err_count = 0, compares = 0, n_done = 0;
    adcps_top i_dut (.*);
    adcps_conv_model i_conv (.*);
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) #1 {lag, salt} = 12'($urandom);
    // result store of the bench: a capture counts only while polling
    always @(posedge ref_clk) begin
        if (conv_done && en_m) begin
            mem[conv_data[2:0]] = conv_data;
            n_done++;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge ref_clk);
        #1 reg_wr = 1'b0;
        if (a == ADCPS_OFS_CONFIG) en_m = d[7:4] == 4'ha;
    endtask
    task automatic rd(input logic [7:0] a, m, exp);
        @(posedge ref_clk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge ref_clk);
        #1 reg_rd = 1'b0;
        check(reg_rdata & m, exp);
    endtask
    task automatic wait_done(input int n);
        for (int i = 0; i < 4000 && n_done < n; i++) @(posedge ref_clk);
        if (n_done < n) begin
            err_count++;
            finish_test();
        end
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(48216));
        for (int i = 0; i < 8; i++) mem[i] = ADCPS_RESULT_RST;
        repeat (4) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        check({7'h00, host_interrupt_n}, 8'h01);
        rd(ADCPS_OFS_CONFIG, 8'hff, ADCPS_CONFIG_RST);
        rd(8'h0b, 8'hff, 8'h00);
        v = 8'($urandom);
        wr(ADCPS_OFS_INPUT_CURRENT_SENSE, v);
        rd(ADCPS_OFS_INPUT_CURRENT_SENSE, 8'hff, v);
        check({6'h00, input_limit_field}, {6'h00, v[1:0]});
        wr(ADCPS_OFS_CONFIG, 8'h10);
        // the copy reaches the pin one edge after the write lands
        @(posedge ref_clk);
        #1 check({7'h00, converter_buffer_disable}, 8'h01);
        wr(ADCPS_OFS_CONFIG, 8'ha0);
        rd(ADCPS_OFS_CHANNEL, 8'h80, 8'h00);
        wait_done(6);
        rd(ADCPS_OFS_CHANNEL, 8'h80, 8'h00);
        wait_done(14);
        rd(ADCPS_OFS_CHANNEL, 8'h80, 8'h80);
        wr(ADCPS_OFS_CONFIG, 8'h20);
        repeat (16) @(posedge ref_clk);
        for (int c = 0; c < 8; c++) begin
            wr(ADCPS_OFS_CHANNEL, 8'(c));
            repeat (2) @(posedge ref_clk);
            rd(ADCPS_OFS_CHANNEL, 8'hc7, {5'h10, 3'(c)});
            rd(ADCPS_OFS_RESULT_HI, 8'hff, mem[c][11:4]);
            rd(ADCPS_OFS_RESULT_LO, 8'hff, {mem[c][3:0], 4'h0});
        end
        wr(ADCPS_OFS_CONFIG, 8'ha0);
        rd(ADCPS_OFS_CHANNEL, 8'h80, 8'h00);
        finish_test();
    end
endmodule
